/* File: shared/gpcs_params.svh */
// Offsets, field positions and reset values of the port and chip-select logic
`ifndef GPCS_PARAMS_SVH
`define GPCS_PARAMS_SVH

// Port register offsets inside the I/O window, bank 0
`define GPCS_OFF_A_VALUE      3'h0
`define GPCS_OFF_A_DIRECTION  3'h1
`define GPCS_OFF_A_DRIVE_KIND 3'h2
`define GPCS_OFF_A_PULLUP     3'h3
`define GPCS_OFF_B_VALUE      3'h4
`define GPCS_OFF_B_DIRECTION  3'h5
`define GPCS_OFF_B_DRIVE_KIND 3'h6
`define GPCS_OFF_B_PULLUP     3'h7
`define GPCS_WINDOW_MASK      16'hfff8

// Reset values
`define GPCS_RST_VALUE        8'hff
`define GPCS_RST_DIRECTION    8'h00
`define GPCS_RST_DRIVE_KIND   8'h00
`define GPCS_RST_PULLUP       8'hff
`define GPCS_RST_CS_REG       8'h00

// First-level configuration indexes
`define GPCS_CFG_CS_INDEX     8'h23
`define GPCS_CFG_CS_DATA      8'h24

// Second-level chip-select registers: four slots per output
`define GPCS_CS_SLOTS         12
`define GPCS_CS_SLOT_BASE_HI  2'h0
`define GPCS_CS_SLOT_BASE_LO  2'h1
`define GPCS_CS_SLOT_CONFIG   2'h2

// Bit positions of the loose selection inputs
`define GPCS_PC3_A_BIT6       0
`define GPCS_PC3_A_BIT5       1
`define GPCS_PC3_IR_RX1       3
`define GPCS_PC3_C_BIT7       4
`define GPCS_PC5_C_BIT3       6
`define GPCS_CFG1_C_SERIAL    3
`define GPCS_CFG1_B_EXPANSION 4
`define GPCS_CFG3_B_PARALLEL  0
`define GPCS_CFG2_BANK        7

`endif

/* File: shared/gpcs_pkg.sv */
// Types shared by the port and chip-select design files
package gpcs_pkg;

  // Pin drive bundle for an eight-bit port
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } gpcs_drive8_t;

  // Layout of a chip-select configuration byte
  typedef struct packed {
    logic wr_qual;
    logic rd_qual;
    logic mask_a4_11;
    logic mask_a3;
    logic mask_a2;
    logic mask_a1;
    logic mask_a0;
    logic enable;
  } gpcs_cs_cfg_t;

  // Host bus cycle as seen by the decoders
  typedef struct packed {
    logic [15:0] addr;
    logic        aen;
    logic        rd_n;
    logic        wr_n;
  } gpcs_bus_t;

  // Kind of a second-level chip-select slot
  typedef enum logic [1:0] {
    GPCS_SLOT_BASE_HI,
    GPCS_SLOT_BASE_LO,
    GPCS_SLOT_CONFIG,
    GPCS_SLOT_RSVD
  } gpcs_slot_t;

endpackage : gpcs_pkg

/* File: rtl/gpcs_chip_select.sv */
// One programmable chip-select decoder with masks and strobe qualification
`timescale 1ns/1ps
module gpcs_chip_select
  import gpcs_pkg::*;
(
  // Clock, reset, enable
  input  wire logic         mclk_i,
  input  wire logic         reset_i,
  input  wire logic         ce_i,
  // Programming
  input  wire logic [15:0]  base_i,
  input  wire gpcs_cs_cfg_t cfg_i,
  input  wire logic         fe_enable_i,
  // Host bus
  input  wire gpcs_bus_t    bus_i,
  // Result, active high
  output logic              select_o
);

  logic [15:0] care;
  logic        match;
  logic        qual;
  logic        select_q;

  // Masked bits are left out of the compare
  always_comb begin
    care        = 16'hffff;
    care[0]     = ~cfg_i.mask_a0;
    care[1]     = ~cfg_i.mask_a1;
    care[2]     = ~cfg_i.mask_a2;
    care[3]     = ~cfg_i.mask_a3;
    care[11:4]  = {8{~cfg_i.mask_a4_11}};
    match       = ~bus_i.aen && (((bus_i.addr ^ base_i) & care) == 16'h0000);
    // No qualifier bit set means address and AEN alone
    case ({cfg_i.wr_qual, cfg_i.rd_qual})
      2'b01:   qual = ~bus_i.rd_n;
      2'b10:   qual = ~bus_i.wr_n;
      2'b11:   qual = ~bus_i.rd_n | ~bus_i.wr_n;
      default: qual = 1'b1;
    endcase
  end

  // Registered so the pin never glitches on address skew
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      select_q <= 1'b0;
    end else if (ce_i) begin
      select_q <= fe_enable_i && cfg_i.enable && match && qual;
    end
  end

  assign select_o = select_q;

endmodule : gpcs_chip_select

/* File: rtl/gpcs_top.sv */
// Two eight-bit ports, pin sharing and three chip-select outputs
`timescale 1ns/1ps
`include "gpcs_params.svh"

module gpcs_top
  import gpcs_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        mclk_i,
  input  wire logic        reset_i,
  input  wire logic        ce_i,
  // Host I/O bus, synchronous to mclk_i
  input  wire logic [15:0] isa_addr_i,
  input  wire logic        isa_aen_i,
  input  wire logic        isa_ior_n_i,
  input  wire logic        isa_iow_n_i,
  input  wire logic [7:0]  isa_data_i,
  output logic [7:0]       isa_data_o,
  output logic             isa_data_oe_o,
  // Window placement and activation
  input  wire logic [15:0] port_base_i,
  input  wire logic        port_active_i,
  // Loose configuration bits from other logic
  input  wire logic [7:0]  config_1_i,
  input  wire logic [7:0]  config_2_i,
  input  wire logic [7:0]  config_3_i,
  input  wire logic [7:0]  power_control_3_i,
  input  wire logic [7:0]  power_control_5_i,
  input  wire logic [2:0]  function_enable_2_cs_i,
  // Chip-select configuration access
  input  wire logic [7:0]  cfg_index_i,
  input  wire logic        cfg_write_i,
  input  wire logic [7:0]  cfg_wdata_i,
  output logic [7:0]       cfg_rdata_o,
  // Port A pins
  input  wire logic [7:0]  port_a_pin_i,
  output logic [7:0]       port_a_pin_o,
  output logic [7:0]       port_a_pin_oe_o,
  output logic [7:0]       port_a_pullup_o,
  // Port B pins; bits 4 and 5 are the expansion_data_2/3 pins
  input  wire logic [7:0]  port_b_pin_i,
  output logic [7:0]       port_b_pin_o,
  output logic [7:0]       port_b_pin_oe_o,
  output logic [7:0]       port_b_pullup_o,
  // Alternate pins for port B bits 4 and 5
  input  wire logic        infrared_receive_1_i,
  output logic             infrared_receive_1_o,
  output logic             infrared_receive_1_oe_o,
  input  wire logic        parallel_16_i,
  output logic             parallel_16_o,
  output logic             parallel_16_oe_o,
  // Pin ownership flags
  output logic [7:0]       port_a_owns_o,
  output logic [7:0]       port_b_owns_o,
  output logic             port_b_bit4_ir_owns_o,
  output logic             port_b_bit5_par_owns_o,
  output logic [7:0]       port_c_owns_o,
  // Chip-select pins, active low
  output logic             select_out_0_o,
  output logic             select_out_0_oe_o,
  output logic             select_out_1_n_o,
  output logic             select_out_2_n_o
);

  // Port registers
  logic [7:0] a_value_q, a_dir_q, a_kind_q, a_pull_q;
  logic [7:0] b_value_q, b_dir_q, b_kind_q, b_pull_q;
  // Chip-select second-level registers
  logic [7:0] cs_reg_q [`GPCS_CS_SLOTS];
  logic [7:0] cs_index_q;
  // Pin synchronisers: three stages and a filtered level
  logic [7:0] a_s1_q, a_s2_q, a_s3_q, a_pin_q;
  logic [7:0] b_s1_q, b_s2_q, b_s3_q, b_pin_q;
  logic [2:0] x_s1_q, x_s2_q, x_s3_q, x_pin_q;
  // Bus strobe history and read data
  logic       iow_n_q;
  logic [7:0] rdata_q;
  logic       hit;
  logic       wr_pulse;
  logic [2:0] off;
  logic [7:0] b_in;
  gpcs_drive8_t a_drv, b_drv;
  gpcs_bus_t    bus;
  logic [2:0]   cs_sel;

  // Slot kind inside a group of four second-level registers
  function automatic gpcs_slot_t slot_kind(input logic [7:0] idx);
    case (idx[1:0])
      `GPCS_CS_SLOT_BASE_HI: slot_kind = GPCS_SLOT_BASE_HI;
      `GPCS_CS_SLOT_BASE_LO: slot_kind = GPCS_SLOT_BASE_LO;
      `GPCS_CS_SLOT_CONFIG:  slot_kind = GPCS_SLOT_CONFIG;
      default:               slot_kind = GPCS_SLOT_RSVD;
    endcase
  endfunction : slot_kind

  // Open-drain or push-pull drive for one port
  function automatic gpcs_drive8_t port_drive(input logic [7:0] value, input logic [7:0] dir,
                                              input logic [7:0] kind, input logic [7:0] owns);
    gpcs_drive8_t d;
    d.out = value & kind;
    d.oe  = dir & owns & (kind | ~value);
    port_drive = d;
  endfunction : port_drive

  // Window decode; bank 1 is not present so it never answers
  assign off      = isa_addr_i[2:0];
  assign hit      = port_active_i && !isa_aen_i && !config_2_i[`GPCS_CFG2_BANK] &&
                    ((isa_addr_i & `GPCS_WINDOW_MASK) == port_base_i);
  assign wr_pulse = hit && !isa_iow_n_i && iow_n_q;

  // Write strobe edge detector
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      iow_n_q <= 1'b1;
    end else if (ce_i) begin
      iow_n_q <= isa_iow_n_i;
    end
  end

  // Port A registers; writes to input bits only reach the latch
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      a_value_q <= `GPCS_RST_VALUE;
      a_dir_q   <= `GPCS_RST_DIRECTION;
      a_kind_q  <= `GPCS_RST_DRIVE_KIND;
      a_pull_q  <= `GPCS_RST_PULLUP;
    end else if (ce_i && wr_pulse) begin
      case (off)
        `GPCS_OFF_A_VALUE:      a_value_q <= isa_data_i;
        `GPCS_OFF_A_DIRECTION:  a_dir_q   <= isa_data_i;
        `GPCS_OFF_A_DRIVE_KIND: a_kind_q  <= isa_data_i;
        `GPCS_OFF_A_PULLUP:     a_pull_q  <= isa_data_i;
        default: ;
      endcase
    end
  end

  // Port B registers at the upper four offsets
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      b_value_q <= `GPCS_RST_VALUE;
      b_dir_q   <= `GPCS_RST_DIRECTION;
      b_kind_q  <= `GPCS_RST_DRIVE_KIND;
      b_pull_q  <= `GPCS_RST_PULLUP;
    end else if (ce_i && wr_pulse) begin
      case (off)
        `GPCS_OFF_B_VALUE:      b_value_q <= isa_data_i;
        `GPCS_OFF_B_DIRECTION:  b_dir_q   <= isa_data_i;
        `GPCS_OFF_B_DRIVE_KIND: b_kind_q  <= isa_data_i;
        `GPCS_OFF_B_PULLUP:     b_pull_q  <= isa_data_i;
        default: ;
      endcase
    end
  end

  // Three-stage pin synchronisers; level moves once stages two and three agree
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      a_s1_q  <= 8'h00;
      a_s2_q  <= 8'h00;
      a_s3_q  <= 8'h00;
      a_pin_q <= 8'h00;
      b_s1_q  <= 8'h00;
      b_s2_q  <= 8'h00;
      b_s3_q  <= 8'h00;
      b_pin_q <= 8'h00;
      x_s1_q  <= 3'h0;
      x_s2_q  <= 3'h0;
      x_s3_q  <= 3'h0;
      x_pin_q <= 3'h0;
    end else if (ce_i) begin
      a_s1_q  <= port_a_pin_i;
      a_s2_q  <= a_s1_q;
      a_s3_q  <= a_s2_q;
      a_pin_q <= (a_s2_q & a_s3_q) | (a_pin_q & (a_s2_q ^ a_s3_q));
      b_s1_q  <= port_b_pin_i;
      b_s2_q  <= b_s1_q;
      b_s3_q  <= b_s2_q;
      b_pin_q <= (b_s2_q & b_s3_q) | (b_pin_q & (b_s2_q ^ b_s3_q));
      x_s1_q  <= {1'b0, parallel_16_i, infrared_receive_1_i};
      x_s2_q  <= x_s1_q;
      x_s3_q  <= x_s2_q;
      x_pin_q <= (x_s2_q & x_s3_q) | (x_pin_q & (x_s2_q ^ x_s3_q));
    end
  end

  // Pin ownership from the loose selection bits
  always_comb begin
    port_a_owns_o    = 8'hff;
    port_a_owns_o[5] = power_control_3_i[`GPCS_PC3_A_BIT5];
    port_a_owns_o[6] = power_control_3_i[`GPCS_PC3_A_BIT6];
    port_b_owns_o    = 8'hff;
    port_b_owns_o[4] = config_1_i[`GPCS_CFG1_B_EXPANSION];
    port_b_owns_o[5] = config_1_i[`GPCS_CFG1_B_EXPANSION];
    port_b_bit4_ir_owns_o  = power_control_3_i[`GPCS_PC3_IR_RX1];
    port_b_bit5_par_owns_o = config_3_i[`GPCS_CFG3_B_PARALLEL];
    port_c_owns_o    = {8{config_1_i[`GPCS_CFG1_C_SERIAL]}};
    port_c_owns_o[3] = power_control_5_i[`GPCS_PC5_C_BIT3];
    port_c_owns_o[7] = power_control_3_i[`GPCS_PC3_C_BIT7];
  end

  // Shared input bits read the alternate pin when it is selected
  always_comb begin
    b_in    = b_pin_q;
    b_in[4] = port_b_bit4_ir_owns_o ? x_pin_q[0] : b_pin_q[4];
    b_in[5] = port_b_bit5_par_owns_o ? x_pin_q[1] : b_pin_q[5];
  end

  // Pin drive, one value may feed two pins at once
  assign a_drv = port_drive(a_value_q, a_dir_q, a_kind_q, port_a_owns_o);
  assign b_drv = port_drive(b_value_q, b_dir_q, b_kind_q, port_b_owns_o);
  assign port_a_pin_o    = a_drv.out;
  assign port_a_pin_oe_o = a_drv.oe;
  assign port_b_pin_o    = b_drv.out;
  assign port_b_pin_oe_o = b_drv.oe;
  assign port_a_pullup_o = a_pull_q;
  assign port_b_pullup_o = b_pull_q;
  assign infrared_receive_1_o    = b_value_q[4] & b_kind_q[4];
  assign infrared_receive_1_oe_o = b_dir_q[4] & port_b_bit4_ir_owns_o & (b_kind_q[4] | ~b_value_q[4]);
  assign parallel_16_o           = b_value_q[5] & b_kind_q[5];
  assign parallel_16_oe_o        = b_dir_q[5] & port_b_bit5_par_owns_o & (b_kind_q[5] | ~b_value_q[5]);

  // Read data staged every cycle; outputs return latch, inputs the pin
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      rdata_q <= 8'h00;
    end else if (ce_i) begin
      case (off)
        `GPCS_OFF_A_VALUE:      rdata_q <= (a_dir_q & a_value_q) | (~a_dir_q & a_pin_q);
        `GPCS_OFF_A_DIRECTION:  rdata_q <= a_dir_q;
        `GPCS_OFF_A_DRIVE_KIND: rdata_q <= a_kind_q;
        `GPCS_OFF_A_PULLUP:     rdata_q <= a_pull_q;
        `GPCS_OFF_B_VALUE:      rdata_q <= (b_dir_q & b_value_q) | (~b_dir_q & b_in);
        `GPCS_OFF_B_DIRECTION:  rdata_q <= b_dir_q;
        `GPCS_OFF_B_DRIVE_KIND: rdata_q <= b_kind_q;
        default:                rdata_q <= b_pull_q;
      endcase
    end
  end

  // Bus driven only while a read strobe hits the window
  assign isa_data_o    = rdata_q;
  assign isa_data_oe_o = hit && !isa_ior_n_i;

  // First-level index, then second-level register file
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      cs_index_q <= 8'h00;
    end else if (ce_i && cfg_write_i && cfg_index_i == `GPCS_CFG_CS_INDEX) begin
      cs_index_q <= cfg_wdata_i;
    end
  end

  // Second-level slots as flops; reserved slots never store
  generate
    for (genvar i = 0; i < `GPCS_CS_SLOTS; i++) begin : g_slot
      always_ff @(posedge mclk_i) begin
        if (reset_i) begin
          cs_reg_q[i] <= `GPCS_RST_CS_REG;
        end else if (ce_i && cfg_write_i && cfg_index_i == `GPCS_CFG_CS_DATA &&
                     cs_index_q == 8'(i) && slot_kind(8'(i)) != GPCS_SLOT_RSVD) begin
          cs_reg_q[i] <= cfg_wdata_i;
        end
      end
    end
  endgenerate

  // Configuration read-back; reserved and out-of-range read as zero
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      cfg_rdata_o <= 8'h00;
    end else if (ce_i) begin
      if (cfg_index_i == `GPCS_CFG_CS_INDEX) begin
        cfg_rdata_o <= cs_index_q;
      end else if (cfg_index_i == `GPCS_CFG_CS_DATA && cs_index_q < 8'(`GPCS_CS_SLOTS) &&
                   slot_kind(cs_index_q) != GPCS_SLOT_RSVD) begin
        cfg_rdata_o <= cs_reg_q[cs_index_q[3:0]];
      end else begin
        cfg_rdata_o <= 8'h00;
      end
    end
  end

  // Chip-select decoders, one per output
  assign bus = '{addr: isa_addr_i, aen: isa_aen_i, rd_n: isa_ior_n_i, wr_n: isa_iow_n_i};
  generate
    for (genvar c = 0; c < 3; c++) begin : g_cs
      gpcs_chip_select u_cs (
        .mclk_i      (mclk_i),
        .reset_i     (reset_i),
        .ce_i        (ce_i),
        .base_i      ({cs_reg_q[4*c], cs_reg_q[4*c+1]}),
        .cfg_i       (gpcs_cs_cfg_t'(cs_reg_q[4*c+2])),
        .fe_enable_i (function_enable_2_cs_i[c]),
        .bus_i       (bus),
        .select_o    (cs_sel[c])
      );
    end
  endgenerate

  // Output 0 only pulls low; the others drive both levels
  assign select_out_0_o    = 1'b0;
  assign select_out_0_oe_o = cs_sel[0];
  assign select_out_1_n_o  = ~cs_sel[1];
  assign select_out_2_n_o  = ~cs_sel[2];

endmodule : gpcs_top

/* File: sim/gpcs_top_assertions.sv */
// Concurrent checks on the port and chip-select top level
`timescale 1ns/1ps
module gpcs_top_assertions (
  // Clock, reset, enable
  input wire logic        mclk_i,
  input wire logic        reset_i,
  input wire logic        ce_i,
  // Host bus and window
  input wire logic [15:0] isa_addr_i,
  input wire logic        isa_aen_i,
  input wire logic        isa_ior_n_i,
  input wire logic        isa_iow_n_i,
  input wire logic [7:0]  isa_data_i,
  input wire logic        isa_data_oe_o,
  input wire logic [15:0] port_base_i,
  input wire logic        port_active_i,
  // Selection inputs
  input wire logic [7:0]  config_1_i,
  input wire logic [7:0]  config_2_i,
  input wire logic [7:0]  power_control_3_i,
  input wire logic [7:0]  power_control_5_i,
  // Pin side
  input wire logic [7:0]  port_a_pin_oe_o,
  input wire logic [7:0]  port_a_pullup_o,
  input wire logic [7:0]  port_a_owns_o,
  input wire logic [7:0]  port_b_pin_o,
  input wire logic [7:0]  port_b_pin_oe_o,
  input wire logic [7:0]  port_b_owns_o,
  input wire logic        port_b_bit4_ir_owns_o,
  input wire logic        infrared_receive_1_o,
  input wire logic        infrared_receive_1_oe_o,
  input wire logic [7:0]  port_c_owns_o,
  input wire logic        select_out_0_o
);
  logic hit;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  // Window decode as the host sees it
  assign hit = port_active_i && !isa_aen_i && !config_2_i[7] && isa_addr_i[15:3] == port_base_i[15:3];

  // Falling write strobe on the port A pull-up register
  sequence pull_write_s;
    hit && ce_i && !isa_iow_n_i && $past(isa_iow_n_i) && isa_addr_i[2:0] == 3'h3;
  endsequence

  read_enable_a: assert property (isa_data_oe_o == (hit && !isa_ior_n_i))
    else $error("read enable differs from window decode");
  pullup_write_a: assert property (pull_write_s |=> port_a_pullup_o == $past(isa_data_i))
    else $error("pull-up write not applied");
  owned_drive_a: assert property ((port_a_pin_oe_o & ~port_a_owns_o) == 8'h00)
    else $error("port A drives a pin it does not own");
  port_a_own_a: assert property (port_a_owns_o[6:5] == {power_control_3_i[0], power_control_3_i[1]})
    else $error("port A ownership wrong");
  port_b_own_a: assert property (port_b_owns_o[5:4] == {2{config_1_i[4]}} && port_b_bit4_ir_owns_o == power_control_3_i[3])
    else $error("port B ownership wrong");
  port_c_own_a: assert property (port_c_owns_o == {power_control_3_i[4], {3{config_1_i[3]}}, power_control_5_i[6], {3{config_1_i[3]}}})
    else $error("port C ownership wrong");
  both_pins_a: assert property (port_b_bit4_ir_owns_o && port_b_owns_o[4] |-> infrared_receive_1_oe_o == port_b_pin_oe_o[4] && infrared_receive_1_o == port_b_pin_o[4])
    else $error("shared bit not driven on both pins");
  select_zero_a: assert property (select_out_0_o == 1'b0)
    else $error("open-drain select drives high");
  reset_state_a: assert property (disable iff (1'b0) reset_i && ce_i |=> port_a_pullup_o == 8'hff && port_a_pin_oe_o == 8'h00)
    else $error("reset state wrong");
endmodule : gpcs_top_assertions

bind gpcs_top gpcs_top_assertions u_chk (.*);

/* File: sim/gpcs_pin_model.sv */
// Board-side model of one group of eight pins
`timescale 1ns/1ps
module gpcs_pin_model
  import gpcs_pkg::*;
(
  // Clock
  input  wire logic         mclk_i,
  // Device side
  input  wire gpcs_drive8_t drv_i,
  input  wire logic [7:0]   pull_i,
  // Board side
  input  wire logic         ext_en_i,
  input  wire logic [7:0]   ext_i,
  output logic [7:0]        pin_o
);
  logic [7:0] wander_q = 8'h5a;

  // Floating lines keep moving so a stale level never reads as valid
  always_ff @(posedge mclk_i) begin
    wander_q <= ~wander_q;
  end

  // Device drive wins; a released line goes to the board or the pull-up
  assign pin_o = (drv_i.oe & drv_i.out) | (~drv_i.oe & (ext_en_i ? ext_i : (pull_i | wander_q)));
endmodule : gpcs_pin_model

/* File: sim/gpcs_top_bench.sv */
// Self-checking bench for the port and chip-select block
`timescale 1ns/1ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin failures++; \
  $display("unexpected at %0t: got %h exp %h", $time, (got), (exp)); end end
module gpcs_top_bench;
  logic        mclk_i, reset_i, ce_i, isa_aen_i, isa_ior_n_i, isa_iow_n_i, isa_data_oe_o, port_active_i;
  logic        cfg_write_i, infrared_receive_1_i, infrared_receive_1_o, infrared_receive_1_oe_o, parallel_16_i;
  logic        parallel_16_o, parallel_16_oe_o, port_b_bit4_ir_owns_o, port_b_bit5_par_owns_o;
  logic        select_out_0_o, select_out_0_oe_o, select_out_1_n_o, select_out_2_n_o;
  logic [15:0] isa_addr_i, port_base_i, base;
  logic [7:0]  isa_data_i, isa_data_o, config_1_i, config_2_i, config_3_i, power_control_3_i, power_control_5_i;
  logic [7:0]  cfg_index_i, cfg_wdata_i, cfg_rdata_o, port_a_pin_i, port_a_pin_o, port_a_pin_oe_o, port_a_pullup_o;
  logic [7:0]  port_b_pin_i, port_b_pin_o, port_b_pin_oe_o, port_b_pullup_o, port_a_owns_o, port_b_owns_o;
  logic [7:0]  port_c_owns_o, ext_a, ext_b, alt_pin, cfg, d, regs[8];
  logic [2:0]  function_enable_2_cs_i, off;
  logic [1:0]  ext_alt;
  int          failures, checks, seed, k, c, r, s;

  gpcs_top uut (.*);

  // Board side of both ports and of the two alternate pins
  gpcs_pin_model pins_a (.mclk_i(mclk_i), .drv_i({port_a_pin_o, port_a_pin_oe_o}), .pull_i(port_a_pullup_o),
    .ext_en_i(1'b1), .ext_i(ext_a), .pin_o(port_a_pin_i));
  gpcs_pin_model pins_b (.mclk_i(mclk_i), .drv_i({port_b_pin_o, port_b_pin_oe_o}), .pull_i(port_b_pullup_o),
    .ext_en_i(1'b1), .ext_i(ext_b), .pin_o(port_b_pin_i));
  gpcs_pin_model pins_alt (.mclk_i(mclk_i), .pull_i(8'h00), .ext_en_i(1'b1), .ext_i({6'h0, ext_alt}), .pin_o(alt_pin),
    .drv_i({6'h0, parallel_16_o, infrared_receive_1_o, 6'h0, parallel_16_oe_o, infrared_receive_1_oe_o}));
  assign infrared_receive_1_i = alt_pin[0];
  assign parallel_16_i = alt_pin[1];

  // Free-running clock
  initial begin
    mclk_i = 0;
    forever #5 mclk_i = ~mclk_i;
  end

  // Model read value: pin for inputs, latch for outputs
  function automatic logic [7:0] exp_rd(input logic [2:0] o);
    logic [7:0] pin;
    logic [7:0] dir;
    pin = {ext_b[7:6], config_3_i[0] ? ext_alt[1] : ext_b[5], power_control_3_i[3] ? ext_alt[0] : ext_b[4], ext_b[3:0]};
    pin = o[2] ? pin : ext_a;
    dir = regs[{o[2], 2'h1}];
    return o[1:0] != 2'h0 ? regs[o] : (regs[o] & dir) | (pin & ~dir);
  endfunction : exp_rd

  // Model select: unmasked bits equal, no DMA cycle, strobe qualified
  function automatic logic cs_exp();
    logic [15:0] msk;
    msk = {4'h0, {8{cfg[5]}}, cfg[4:1]};
    return cfg[0] && function_enable_2_cs_i[c] && !isa_aen_i && ((isa_addr_i ^ base) & ~msk) == 16'h0 &&
      (cfg[7:6] == 2'h0 || (cfg[6] && !isa_ior_n_i) || (cfg[7] && !isa_iow_n_i));
  endfunction : cs_exp

  task automatic bus_wr(input logic [2:0] o, input logic [7:0] v);
    @(posedge mclk_i) #1;
    isa_addr_i = port_base_i | {13'h0, o};
    isa_data_i = v;
    isa_iow_n_i = 0;
    @(posedge mclk_i) #1;
    isa_iow_n_i = 1;
  endtask : bus_wr

  task automatic bus_rd(input logic [2:0] o);
    @(posedge mclk_i) #1;
    isa_addr_i = port_base_i | {13'h0, o};
    isa_ior_n_i = 0;
    @(posedge mclk_i) #1;
    `CHK(isa_data_o, exp_rd(o))
    `CHK(isa_data_oe_o, 1'b1)
    isa_ior_n_i = 1;
  endtask : bus_rd

  task automatic cfg_wr(input logic [7:0] idx, input logic [7:0] v);
    @(posedge mclk_i) #1;
    cfg_index_i = idx;
    cfg_wdata_i = v;
    cfg_write_i = 1;
    @(posedge mclk_i) #1;
    cfg_write_i = 0;
  endtask : cfg_wr

  // Pin drive follows direction, drive kind, latch and pull-up
  task automatic check_pins();
    `CHK(port_a_pin_oe_o, regs[1] & (regs[2] | ~regs[0]))
    `CHK(port_a_pin_o, regs[0] & regs[2])
    `CHK(port_a_pullup_o, regs[3])
    `CHK(port_b_pin_oe_o, regs[5] & (regs[6] | ~regs[4]))
    `CHK(port_b_pin_o, regs[4] & regs[6])
    `CHK(port_b_pullup_o, regs[7])
    `CHK(port_b_bit5_par_owns_o, config_3_i[0])
    `CHK({parallel_16_oe_o, parallel_16_o}, {regs[5][5] & config_3_i[0] & (regs[6][5] | ~regs[4][5]), regs[4][5] & regs[6][5]})
  endtask : check_pins

  task automatic give_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : give_verdict

  // Hang guard, far beyond the expected run of some 1400 cycles
  initial begin
    #300000;
    failures++;
    give_verdict();
  end

  // Main sequence
  initial begin
    seed = 62;
    failures = 0;
    checks = 0;
    reset_i = 1;
    ce_i = 1;
    {isa_addr_i, isa_aen_i, isa_ior_n_i, isa_iow_n_i, isa_data_i} = {16'h0, 1'b0, 1'b1, 1'b1, 8'h00};
    port_base_i = 16'h0e00;
    port_active_i = 1;
    {config_1_i, config_2_i, config_3_i, power_control_3_i, power_control_5_i} = {8'h10, 8'h00, 8'h01, 8'h0b, 8'h00};
    {function_enable_2_cs_i, cfg_index_i, cfg_write_i, cfg_wdata_i} = '0;
    {ext_a, ext_b, ext_alt} = {8'h3c, 8'ha5, 2'b01};
    regs = '{8'hff, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'hff};
    repeat (12) @(posedge mclk_i);
    #1 reset_i = 0;
    // Pin synchronisers need four edges before a pin level reads back
    repeat (4) @(posedge mclk_i);
    for (k = 0; k < 8; k++) begin
      bus_rd(3'(k));
    end
    check_pins();
    // Random register traffic, with ownership and board levels moving
    for (k = 0; k < 80; k++) begin
      if (k % 16 == 0) begin
        {ext_a, ext_b, ext_alt} = 18'($random(seed));
        power_control_3_i = 8'($random(seed)) | 8'h03;
        power_control_5_i = 8'($random(seed));
        config_1_i = 8'($random(seed)) | 8'h10;
        config_3_i = 8'($random(seed));
      end
      off = 3'($random(seed));
      d = 8'($random(seed));
      bus_wr(off, d);
      regs[off] = d;
      repeat (5) @(posedge mclk_i);
      bus_rd(3'($random(seed)));
      check_pins();
    end
    // Writes refused in bank 1, in a DMA cycle, while inactive and while frozen
    for (k = 0; k < 4; k++) begin
      config_2_i = {k == 0, 7'h00};
      isa_aen_i = k == 1;
      port_active_i = k != 2;
      ce_i = k != 3;
      bus_wr(3'h1, ~regs[1]);
      {config_2_i, isa_aen_i, port_active_i, ce_i} = {8'h00, 1'b0, 1'b1, 1'b1};
      bus_rd(3'h1);
    end
    // Each select in each qualifier mode, random masks and addresses
    port_active_i = 0;
    for (k = 0; k < 12; k++) begin
      c = k % 3;
      base = 16'($random(seed));
      cfg = {2'(k / 3), 5'($random(seed)), 1'b1};
      cfg_wr(8'h23, 8'(4 * c));
      cfg_wr(8'h24, base[15:8]);
      cfg_wr(8'h23, 8'(4 * c + 1));
      cfg_wr(8'h24, base[7:0]);
      cfg_wr(8'h23, 8'(4 * c + 2));
      cfg_wr(8'h24, cfg);
      cfg_index_i = 8'h24;
      @(posedge mclk_i) #1;
      `CHK(cfg_rdata_o, cfg)
      repeat (40) begin
        r = $random(seed);
        s = $random(seed);
        isa_addr_i = base ^ (16'(r) & (16'hffff >> (4 * (r[31:29] % 5))));
        isa_ior_n_i = s[0];
        isa_iow_n_i = s[1] | !s[0];
        isa_aen_i = s[4:2] == 3'h0;
        function_enable_2_cs_i = s[7:5];
        @(posedge mclk_i) #1;
        `CHK(c == 0 ? select_out_0_oe_o : !(c == 1 ? select_out_1_n_o : select_out_2_n_o), cs_exp())
      end
    end
    give_verdict();
  end
endmodule : gpcs_top_bench
